// file: dv/osr_checker.sv
// Port-level checks on the output router
module osr_checker (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [15:0] fast_out_a,
    input wire logic [15:0] slow_out_a,
    input wire logic        bw_change,
    input wire logic        mod70_en,
    input wire logic [15:0] zero_store_level,
    input wire logic        zero_store_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking osr_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // Write of a register, then its read one cycle later
    sequence wr_then_rd(a);
        reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
    endsequence
    // Disabled channel drives a zero code two edges on
    property chan_off(a, o);
        reg_wr && reg_addr == a && !reg_wdata[9] |=> ##1 o == 16'h0000;
    endproperty
    rd_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("rdata outside slot");
    unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 32'h0)
        else $error("unmapped read");
    mix_back_a: assert property (wr_then_rd(8'h04) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("mix readback");
    ctrl_back_a: assert property (wr_then_rd(8'h00) |=>
        reg_rdata[7:4] == $past(reg_wdata[7:4], 2)) else $error("enable readback");
    mod70_set_a: assert property (reg_wr && reg_addr == 8'h00 |=>
        mod70_en == $past(reg_wdata[0])) else $error("mod70 not taken");
    save_flag_a: assert property (reg_wr && reg_addr == 8'h08 |=> ##1
        zero_store_en == ($past(reg_wdata[1:0], 2) == 2'h3)) else $error("store flag");
    zero_hold_a: assert property (zero_store_en && bw_change && !reg_wr && !$past(reg_wr)
        |=> $stable(zero_store_level)) else $error("saved zero moved");
    fast_off_a: assert property (chan_off(8'h80, fast_out_a))
        else $error("fast not off");
    slow_off_a: assert property (chan_off(8'hC0, slow_out_a))
        else $error("slow not off");
endmodule

// file: dv/osr_nv_model.sv
// Nonvolatile store beside the block; keeps the saved zero across resets
module osr_nv_model (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        store_en,     // Save mode active
    input  wire logic [15:0] store_level,  // Level to keep
    output logic             nv_saved = 1'b0,    // Stored level valid
    output logic [15:0]      nv_level = 16'h0000 // Stored level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Follows the block only while rst_b is high, so reset never wipes it
    always @(posedge clk_sys) begin
        if (rst_b) begin
            nv_saved <= store_en;
            if (store_en) begin
                nv_level <= store_level;
            end
        end
    end
endmodule

// file: dv/tb.sv
`include "osr_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Row: channel window, config, scale, offset, expected code
    typedef struct packed {
        logic [7:0]  a;
        logic [9:0]  cfg;
        logic [15:0] scl;
        logic [11:0] off;
        logic [15:0] exp;
    } osr_row;
    logic        clk_sys = 1'b0;
    logic        rst_b;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        freq_change = 1'b0, bw_change = 1'b0;
    logic [15:0] fsrc [0:14];   // Fast sources by code
    logic [15:0] ssrc [0:15];   // Slow sources by code
    logic [15:0] mix_a;         // First mixed sample
    wire  [15:0] outs [0:7];    // Fast A-D then slow A-D
    wire  [31:0] reg_rdata;
    wire         mod70_en, zero_store_en, nv_saved;
    wire  [15:0] zero_store_level, nv_level;
    int          errors = 0;
    int          check_count = 0;
    osr_row      rows [0:9] = '{
        '{8'h80, 10'h302, 16'h0100, 12'h000, 16'hFD00},
        '{8'h80, 10'h202, 16'h0200, 12'h000, 16'h0600},
        '{8'h80, 10'h202, 16'hFF80, 12'h000, 16'hFE80},
        '{8'h80, 10'h202, 16'h0100, 12'h100, 16'h1300},
        '{8'h80, 10'h202, 16'h0100, 12'h800, 16'h8300},
        '{8'h80, 10'h202, 16'h7FFF, 12'h000, 16'h7FFF},
        '{8'h80, 10'h202, 16'h8000, 12'h000, 16'h8000},
        '{8'h80, 10'h002, 16'h0100, 12'h000, 16'h0000},
        '{8'hC0, 10'h211, 16'h0100, 12'h000, 16'h7FFF},
        '{8'hC0, 10'h011, 16'h0100, 12'h000, 16'h0000}};
    osr_router osr_router_inst (
        .clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .phys0_intermediate_input(fsrc[0]), .phys1_intermediate_input(fsrc[1]),
        .phys0_baseband_inphase(fsrc[2]), .phys0_baseband_quadrature(fsrc[3]),
        .phys0_tape_source(fsrc[4]), .phys1_baseband_inphase(fsrc[5]),
        .phys1_baseband_quadrature(fsrc[6]), .phys1_tape_source(fsrc[7]),
        .combiner_inphase(fsrc[8]), .combiner_quadrature(fsrc[9]),
        .combiner_tape_source(fsrc[10]), .fast_datapath({fsrc[14], fsrc[13], fsrc[12], fsrc[11]}),
        .demod_am(ssrc[0]), .gain_level(ssrc[1]), .combiner_weight_source(ssrc[2]),
        .slow_datapath({ssrc[6], ssrc[5], ssrc[4], ssrc[3]}), .quality_decode(ssrc[7]),
        .quality_datapath(ssrc[8]), .quality_output(ssrc[9]), .dsp_snr_zero(ssrc[10]),
        .dsp_snr_one(ssrc[11]), .external_gain_level_zero(ssrc[12]),
        .external_gain_level_one(ssrc[13]), .internal_gain_level_zero(ssrc[14]),
        .internal_gain_level_one(ssrc[15]), .freq_change, .bw_change,
        .nv_zero_saved(nv_saved), .nv_zero_level(nv_level),
        .fast_out_a(outs[0]), .fast_out_b(outs[1]), .fast_out_c(outs[2]), .fast_out_d(outs[3]),
        .slow_out_a(outs[4]), .slow_out_b(outs[5]), .slow_out_c(outs[6]), .slow_out_d(outs[7]),
        .mod70_en, .zero_store_level, .zero_store_en);
    osr_nv_model osr_nv_model_inst (.clk_sys, .rst_b, .store_en(zero_store_en),
        .store_level(zero_store_level), .nv_saved, .nv_level);
    // 20 MHz clock
    always #25 clk_sys = ~clk_sys;
    // Compare a register word or flag
    task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Compare a DAC code
    task automatic chk_code(input string n, input logic [15:0] e, input logic [15:0] g);
        chk_reg(n, {16'h0, e}, {16'h0, g});
    endtask
    // Counts, verdict, end of run
    task automatic finish_test;
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Bus write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Bus read, checked in its data slot
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk_reg("read data", e, reg_rdata);
        @(posedge clk_sys);
    endtask
    // One-cycle tuning or bandwidth change pulse
    task automatic pulse(input logic f);
        @(posedge clk_sys);
        freq_change <= f;
        bw_change <= !f;
        @(posedge clk_sys);
        freq_change <= 1'b0;
        bw_change <= 1'b0;
    endtask
    // Config to outputs
    task automatic settle;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // Reset, then restore cycle
    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
    endtask
    // Main sequence
    initial begin
        for (int i = 0; i < 16; i++) begin
            ssrc[i] = 16'(i * 16'h0080 + 16'h0090);
            if (i < 15) fsrc[i] = 16'(i * 16'h0100 + 16'h0100);
        end
        do_reset();
        settle();
        chk_code("fast a", fsrc[11], outs[0]);
        chk_code("fast d", fsrc[3], outs[3]);
        chk_code("slow a", ssrc[0], outs[4]);
        chk_code("slow b", 16'h0000, outs[5]);
        @(posedge clk_sys);
        rd(8'h84, 32'h100);
        rd(`OSR_REG_CTRL, 32'h0);
        rd(`OSR_REG_MIX_FREQ, 32'h0);
        wr(`OSR_REG_ZERO_MODE, 32'h2);
        wr(`OSR_REG_ZERO_SET, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, {22'h0, rows[i].cfg});
            wr(rows[i].a + 8'h04, {16'h0, rows[i].scl});
            wr(rows[i].a + 8'h08, {20'h0, rows[i].off});
            settle();
            chk_code("row", rows[i].exp, outs[rows[i].a[6:4]]);
        end
        // All source codes
        for (int c = 0; c < 18; c++) begin
            if (c < 17) wr(8'h80, 32'h200 | c);
            wr(8'hC0, 32'h200 | c);
            settle();
            if (c < 17) chk_code("fast src", c < 15 ? fsrc[c] : {1'b0, {15{c[4]}}}, outs[0]);
            chk_code("slow src", c < 16 ? ssrc[c] : {1'b0, {15{c[0]}}}, outs[4]);
        end
        for (int c = 0; c < 8; c++) begin
            wr(8'h80 + 8'(16 * c), c < 4 ? 32'h210 : 32'h211);
            settle();
            chk_code("chan high", 16'h7FFF, outs[c]);
        end
        wr(`OSR_REG_MIX_FREQ, 32'h8000_0000);
        rd(`OSR_REG_MIX_FREQ, 32'h8000_0000);
        wr(`OSR_REG_CTRL, 32'h11);
        rd(`OSR_REG_CTRL, 32'h11);
        wr(8'h80, 32'h204);
        settle();
        mix_a = outs[0];
        @(negedge clk_sys);
        chk_code("mix sum", 16'h0000, mix_a + outs[0]);
        chk_code("mix size", fsrc[4], mix_a[15] ? outs[0] : mix_a);
        chk_reg("mod70", 32'h1, {31'h0, mod70_en});
        wr(`OSR_REG_CTRL, 32'h0);
        settle();
        chk_code("bypass", fsrc[4], outs[0]);
        chk_reg("mod70", 32'h0, {31'h0, mod70_en});
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0);
        // Zero modes
        wr(`OSR_REG_ZERO_MODE, 32'h1);
        wr(`OSR_REG_ZERO_SET, 32'h55);
        rd(`OSR_REG_ZERO_STAT, 32'h55);
        pulse(1'b1);
        rd(`OSR_REG_ZERO_STAT, 32'h0);
        wr(`OSR_REG_ZERO_SET, 32'h55);
        pulse(1'b0);
        rd(`OSR_REG_ZERO_STAT, 32'h0);
        wr(`OSR_REG_ZERO_MODE, 32'h2);
        wr(`OSR_REG_ZERO_SET, 32'h55);
        pulse(1'b1);
        pulse(1'b0);
        rd(`OSR_REG_ZERO_STAT, 32'h55);
        wr(`OSR_REG_ZERO_CMD, 32'h1);
        rd(`OSR_REG_ZERO_STAT, {16'h0, ssrc[1]});
        wr(`OSR_REG_ZERO_CMD, 32'h2);
        rd(`OSR_REG_ZERO_STAT, 32'h0);
        wr(`OSR_REG_ZERO_MODE, 32'h3);
        wr(`OSR_REG_ZERO_SET, 32'h55);
        pulse(1'b0);
        settle();
        chk_reg("store", 32'h10055, {15'h0, zero_store_en, zero_store_level});
        do_reset();
        rd(`OSR_REG_ZERO_STAT, 32'h55);
        finish_test();
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        finish_test();
    end
endmodule
bind osr_router osr_checker osr_checker_inst (.*);

// file: hw/osr_chan_cond.v
// Per-channel conditioning: polarity, scale, offset, enable
module osr_chan_cond (
    input  wire               clk_sys,
    input  wire               rst_b,
    input  wire signed [15:0] sample,   // Selected source
    input  wire               pol_inv,  // 1 inverts
    input  wire signed [15:0] scale,    // 8.8 two's complement
    input  wire signed [11:0] offset,   // 1.11 fraction of full scale
    input  wire               chan_en,  // 0 forces output to zero
    output reg  signed [15:0] dac_out   // Registered DAC code
);
    reg signed [16:0] signed_in;  // Input after polarity
    reg signed [33:0] product;    // Full product
    reg signed [26:0] sum;        // Scaled plus offset
    reg signed [15:0] next_dac_out;

    // Arithmetic path with saturation
    always @* begin
        signed_in = pol_inv ? -{sample[15], sample} : {sample[15], sample};
        product   = signed_in * scale;
        sum       = $signed(product[33:8]) + $signed({{11{offset[11]}}, offset, 4'h0});
        if (!chan_en) begin
            next_dac_out = 16'h0000;
        end else if (sum > 27'sh0007FFF) begin
            next_dac_out = 16'h7FFF;
        end else if (sum < -27'sh0008000) begin
            next_dac_out = 16'h8000;
        end else begin
            next_dac_out = sum[15:0];
        end
    end

    // Output register
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dac_out <= 16'h0000;
        end else begin
            dac_out <= next_dac_out;
        end
    end
endmodule

// file: hw/osr_router.v
`include "osr_defines.vh"
module osr_router #(
    parameter MIX_W = 32                       // Mixer phase accumulator width
) (
    input  wire               clk_sys,
    input  wire               rst_b,
    input  wire [7:0]         reg_addr,        // Register byte address
    input  wire [31:0]        reg_wdata,       // Write data
    input  wire               reg_wr,          // Write strobe
    input  wire               reg_rd,          // Read strobe
    output reg  [31:0]        reg_rdata,       // Read data, cycle after strobe
    input  wire [15:0]        phys0_intermediate_input,
    input  wire [15:0]        phys1_intermediate_input,
    input  wire [15:0]        phys0_baseband_inphase,
    input  wire [15:0]        phys0_baseband_quadrature,
    input  wire [15:0]        phys0_tape_source,
    input  wire [15:0]        phys1_baseband_inphase,
    input  wire [15:0]        phys1_baseband_quadrature,
    input  wire [15:0]        phys1_tape_source,
    input  wire [15:0]        combiner_inphase,
    input  wire [15:0]        combiner_quadrature,
    input  wire [15:0]        combiner_tape_source,
    input  wire [63:0]        fast_datapath,   // Datapath signals 0..3, 16 bits each
    input  wire [15:0]        demod_am,
    input  wire [15:0]        gain_level,      // Measured gain-control level
    input  wire [15:0]        combiner_weight_source,
    input  wire [63:0]        slow_datapath,   // Datapath sources 0..3
    input  wire [15:0]        quality_decode,
    input  wire [15:0]        quality_datapath,
    input  wire [15:0]        quality_output,
    input  wire [15:0]        dsp_snr_zero,
    input  wire [15:0]        dsp_snr_one,
    input  wire [15:0]        external_gain_level_zero,
    input  wire [15:0]        external_gain_level_one,
    input  wire [15:0]        internal_gain_level_zero,
    input  wire [15:0]        internal_gain_level_one,
    input  wire               freq_change,     // Pulse: tuning frequency changed
    input  wire               bw_change,       // Pulse: IF bandwidth changed
    input  wire               nv_zero_saved,   // Stored zero is valid at power-up
    input  wire [15:0]        nv_zero_level,   // Stored zero level
    output wire [15:0]        fast_out_a,
    output wire [15:0]        fast_out_b,
    output wire [15:0]        fast_out_c,
    output wire [15:0]        fast_out_d,
    output wire [15:0]        slow_out_a,
    output wire [15:0]        slow_out_b,
    output wire [15:0]        slow_out_c,
    output wire [15:0]        slow_out_d,
    output reg                mod70_en,        // 70 MHz modulator enable
    output reg  [15:0]        zero_store_level, // Level to keep in storage
    output reg                zero_store_en    // Storage should keep level
);
    // Configuration storage, channels 0..3 fast, 4..7 slow
    reg  [4:0]        src_sel [0:7];   // Source code
    reg               pol_inv [0:7];   // Polarity
    reg               chan_en [0:7];   // Channel enable
    reg  [15:0]       scale   [0:7];   // Scale factor
    reg  [11:0]       offset  [0:7];   // Offset
    reg  [3:0]        mix_en;          // Fast mixer enables
    reg  [MIX_W-1:0]  mix_freq;        // Signed tuning word
    reg  [MIX_W-1:0]  mix_phase;       // Accumulated phase
    reg  [1:0]        zero_mode;       // Gain-control zero mode
    reg  [15:0]       zero_level;      // Current zero
    reg               boot_done;       // Power-up restore taken
    reg  [15:0]       sel_sample [0:7];
    reg  [15:0]       gain_out;        // Level minus zero
    reg  [31:0]       next_rdata;
    wire [127:0]      dac_bus;         // All conditioned outputs
    wire              ch_hit;          // Address is in a channel window
    wire [2:0]        ch_idx;          // Channel addressed
    wire [1:0]        ch_fld;          // Channel field addressed
    integer           i;

    assign ch_hit = reg_addr[`OSR_CH_BASE_BIT];
    assign ch_idx = reg_addr[6:4];
    assign ch_fld = reg_addr[3:2];

    // Reset source per channel
    function [4:0] def_src;
        input [2:0] ch;
        begin
            case (ch)
                3'd0:    def_src = `OSR_FS_DP0;
                3'd1:    def_src = `OSR_FS_DP0 + 5'h01;
                3'd2:    def_src = `OSR_FS_P0I;
                3'd3:    def_src = `OSR_FS_P0Q;
                3'd4:    def_src = `OSR_SS_AM;
                3'd6:    def_src = `OSR_SS_AGC;
                default: def_src = `OSR_SS_LOW;
            endcase
        end
    endfunction

    // Fast source selector
    function [15:0] fast_pick;
        input [4:0] sel;
        begin
            case (sel)
                `OSR_FS_IF0:          fast_pick = phys0_intermediate_input;
                `OSR_FS_IF1:          fast_pick = phys1_intermediate_input;
                `OSR_FS_P0I:          fast_pick = phys0_baseband_inphase;
                `OSR_FS_P0Q:          fast_pick = phys0_baseband_quadrature;
                `OSR_FS_P0T:          fast_pick = phys0_tape_source;
                `OSR_FS_P1I:          fast_pick = phys1_baseband_inphase;
                `OSR_FS_P1Q:          fast_pick = phys1_baseband_quadrature;
                `OSR_FS_P1T:          fast_pick = phys1_tape_source;
                `OSR_FS_COMBINER_INPHASE:         fast_pick = combiner_inphase;
                `OSR_FS_COMBINER_QUADRATURE:         fast_pick = combiner_quadrature;
                `OSR_FS_COMBINER_TAPE_SOURCE:         fast_pick = combiner_tape_source;
                `OSR_FS_DP0:          fast_pick = fast_datapath[15:0];
                `OSR_FS_DP0 + 5'h01:  fast_pick = fast_datapath[31:16];
                `OSR_FS_DP0 + 5'h02:  fast_pick = fast_datapath[47:32];
                `OSR_FS_DP0 + 5'h03:  fast_pick = fast_datapath[63:48];
                `OSR_FS_HIGH:         fast_pick = `OSR_FULL_HIGH;
                default:              fast_pick = `OSR_FULL_LOW;
            endcase
        end
    endfunction

    // Slow source selector
    function [15:0] slow_pick;
        input [4:0] sel;
        begin
            case (sel)
                `OSR_SS_AM:           slow_pick = demod_am;
                `OSR_SS_AGC:          slow_pick = gain_out;
                `OSR_SS_COMBINER_WEIGHT_SOURCE:         slow_pick = combiner_weight_source;
                `OSR_SS_DP0:          slow_pick = slow_datapath[15:0];
                `OSR_SS_DP0 + 5'h01:  slow_pick = slow_datapath[31:16];
                `OSR_SS_DP0 + 5'h02:  slow_pick = slow_datapath[47:32];
                `OSR_SS_DP0 + 5'h03:  slow_pick = slow_datapath[63:48];
                `OSR_SS_QUALITY_DECODE:        slow_pick = quality_decode;
                `OSR_SS_QUALITY_DATAPATH:         slow_pick = quality_datapath;
                `OSR_SS_QUALITY_OUTPUT:        slow_pick = quality_output;
                `OSR_SS_DS0:          slow_pick = dsp_snr_zero;
                `OSR_SS_DS1:          slow_pick = dsp_snr_one;
                `OSR_SS_EA0:          slow_pick = external_gain_level_zero;
                `OSR_SS_EA1:          slow_pick = external_gain_level_one;
                `OSR_SS_IA0:          slow_pick = internal_gain_level_zero;
                `OSR_SS_IA1:          slow_pick = internal_gain_level_one;
                `OSR_SS_HIGH:         slow_pick = `OSR_FULL_HIGH;
                default:              slow_pick = `OSR_FULL_LOW;
            endcase
        end
    endfunction

    // Register writes and configuration state
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (i = 0; i < 8; i = i + 1) begin
                src_sel[i] <= def_src(i[2:0]);
                pol_inv[i] <= 1'b0;
                chan_en[i] <= 1'b1;
                scale[i]   <= `OSR_SCALE_ONE;
                offset[i]  <= 12'h000;
            end
            mix_en   <= 4'h0;
            mix_freq <= {MIX_W{1'b0}};
            mod70_en <= 1'b0;
        end else if (reg_wr && ch_hit) begin
            // Channel window write
            case (ch_fld)
                `OSR_CH_CFG: begin
                    src_sel[ch_idx] <= reg_wdata[4:0];
                    pol_inv[ch_idx] <= reg_wdata[`OSR_CFG_POL];
                    chan_en[ch_idx] <= reg_wdata[`OSR_CFG_EN];
                end
                `OSR_CH_SCALE: begin
                    scale[ch_idx] <= reg_wdata[15:0];
                end
                `OSR_CH_OFFSET: begin
                    offset[ch_idx] <= reg_wdata[11:0];
                end
                default: begin
                end
            endcase
        end else if (reg_wr) begin
            // Global register write
            case (reg_addr)
                `OSR_REG_CTRL: begin
                    mod70_en <= reg_wdata[`OSR_CTRL_MOD70];
                    mix_en   <= reg_wdata[`OSR_CTRL_MIX_LSB+3:`OSR_CTRL_MIX_LSB];
                end
                `OSR_REG_MIX_FREQ: begin
                    mix_freq <= reg_wdata[MIX_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Shared mixer phase accumulator
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mix_phase <= {MIX_W{1'b0}};
        end else begin
            mix_phase <= mix_phase + mix_freq;
        end
    end

    // Gain-control zero level handling
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            zero_mode  <= `OSR_ZM_AUTO;
            zero_level <= `OSR_ZERO_NOMINAL;
            boot_done  <= 1'b0;
        end else if (!boot_done) begin
            // First cycle after power-up: restore saved zero
            boot_done <= 1'b1;
            if (nv_zero_saved) begin
                zero_mode  <= `OSR_ZM_SAVE;
                zero_level <= nv_zero_level;
            end
        end else if (reg_wr && reg_addr == `OSR_REG_ZERO_MODE) begin
            zero_mode <= reg_wdata[1:0];
        end else if (reg_wr && reg_addr == `OSR_REG_ZERO_SET) begin
            zero_level <= reg_wdata[15:0];
        end else if (reg_wr && reg_addr == `OSR_REG_ZERO_CMD) begin
            if (reg_wdata[`OSR_CMD_CAPTURE]) begin
                zero_level <= gain_level;
            end else if (reg_wdata[`OSR_CMD_NOMINAL]) begin
                zero_level <= `OSR_ZERO_NOMINAL;
            end
        end else if (zero_mode == `OSR_ZM_MANUAL && (freq_change || bw_change)) begin
            zero_level <= `OSR_ZERO_NOMINAL;
        end else if (zero_mode == `OSR_ZM_AUTO) begin
            // Auto mode walks the zero toward the measured level
            if ($signed(zero_level) < $signed(gain_level)) begin
                zero_level <= zero_level + 16'h0001;
            end else if ($signed(zero_level) > $signed(gain_level)) begin
                zero_level <= zero_level - 16'h0001;
            end
        end
    end

    // Export of zero for non-volatile storage
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            zero_store_level <= `OSR_ZERO_NOMINAL;
            zero_store_en    <= 1'b0;
        end else begin
            zero_store_level <= zero_level;
            zero_store_en    <= (zero_mode == `OSR_ZM_SAVE);
        end
    end

    // Source selection and fast mixing
    always @* begin
        gain_out = gain_level - zero_level;
        for (i = 0; i < 8; i = i + 1) begin
            sel_sample[i] = 16'h0000;
        end
        for (i = 0; i < 4; i = i + 1) begin
            sel_sample[i] = fast_pick(src_sel[i]);
            if (mix_en[i] && mix_phase[MIX_W-1]) begin
                sel_sample[i] = 16'h0000 - fast_pick(src_sel[i]);
            end
            sel_sample[i+4] = slow_pick(src_sel[i+4]);
        end
    end

    // Eight conditioning channels
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gen_ch
            osr_chan_cond u_cond (
                .clk_sys (clk_sys),
                .rst_b   (rst_b),
                .sample  (sel_sample[g]),
                .pol_inv (pol_inv[g]),
                .scale   (scale[g]),
                .offset  (offset[g]),
                .chan_en (chan_en[g]),
                .dac_out (dac_bus[16*g+15:16*g])
            );
        end
    endgenerate

    assign fast_out_a = dac_bus[15:0];
    assign fast_out_b = dac_bus[31:16];
    assign fast_out_c = dac_bus[47:32];
    assign fast_out_d = dac_bus[63:48];
    assign slow_out_a = dac_bus[79:64];
    assign slow_out_b = dac_bus[95:80];
    assign slow_out_c = dac_bus[111:96];
    assign slow_out_d = dac_bus[127:112];

    // Read decode
    always @* begin
        next_rdata = 32'h0000_0000;
        if (ch_hit) begin
            case (ch_fld)
                `OSR_CH_CFG:    next_rdata = {22'h0, chan_en[ch_idx], pol_inv[ch_idx],
                                              3'h0, src_sel[ch_idx]};
                `OSR_CH_SCALE:  next_rdata = {16'h0000, scale[ch_idx]};
                `OSR_CH_OFFSET: next_rdata = {20'h00000, offset[ch_idx]};
                default:        next_rdata = 32'h0000_0000;
            endcase
        end else begin
            case (reg_addr)
                `OSR_REG_CTRL:      next_rdata = {24'h0, mix_en, 3'h0, mod70_en};
                `OSR_REG_MIX_FREQ:  next_rdata = mix_freq;
                `OSR_REG_ZERO_MODE: next_rdata = {30'h0, zero_mode};
                `OSR_REG_ZERO_STAT: next_rdata = {16'h0000, zero_level};
                `OSR_REG_PHASE:     next_rdata = mix_phase;
                default:            next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Read data stands one cycle after the strobe only
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

// file: pkg/osr_defines.vh
`ifndef OSR_DEFINES_VH
`define OSR_DEFINES_VH
// Global register offsets (byte addresses, one word each)
`define OSR_REG_CTRL      8'h00
`define OSR_REG_MIX_FREQ  8'h04
`define OSR_REG_ZERO_MODE 8'h08
`define OSR_REG_ZERO_SET  8'h0C
`define OSR_REG_ZERO_CMD  8'h10
`define OSR_REG_ZERO_STAT 8'h14
`define OSR_REG_PHASE     8'h18
// Channel windows: 0x80 + 0x10 * channel, fast A-D = 0..3, slow A-D = 4..7
`define OSR_CH_BASE_BIT   7
`define OSR_CH_CFG        2'h0
`define OSR_CH_SCALE      2'h1
`define OSR_CH_OFFSET     2'h2
// Control register fields
`define OSR_CTRL_MOD70    0
`define OSR_CTRL_MIX_LSB  4
// Channel config fields
`define OSR_CFG_POL       8
`define OSR_CFG_EN        9
// Zero command fields
`define OSR_CMD_CAPTURE   0
`define OSR_CMD_NOMINAL   1
// Zero modes
`define OSR_ZM_AUTO       2'h0
`define OSR_ZM_MANUAL     2'h1
`define OSR_ZM_HOLD       2'h2
`define OSR_ZM_SAVE       2'h3
// Fast source codes
`define OSR_FS_IF0        5'h00
`define OSR_FS_IF1        5'h01
`define OSR_FS_P0I        5'h02
`define OSR_FS_P0Q        5'h03
`define OSR_FS_P0T        5'h04
`define OSR_FS_P1I        5'h05
`define OSR_FS_P1Q        5'h06
`define OSR_FS_P1T        5'h07
`define OSR_FS_COMBINER_INPHASE       5'h08
`define OSR_FS_COMBINER_QUADRATURE       5'h09
`define OSR_FS_COMBINER_TAPE_SOURCE       5'h0A
`define OSR_FS_DP0        5'h0B
`define OSR_FS_LOW        5'h0F
`define OSR_FS_HIGH       5'h10
// Slow source codes
`define OSR_SS_AM         5'h00
`define OSR_SS_AGC        5'h01
`define OSR_SS_COMBINER_WEIGHT_SOURCE       5'h02
`define OSR_SS_DP0        5'h03
`define OSR_SS_QUALITY_DECODE      5'h07
`define OSR_SS_QUALITY_DATAPATH       5'h08
`define OSR_SS_QUALITY_OUTPUT      5'h09
`define OSR_SS_DS0        5'h0A
`define OSR_SS_DS1        5'h0B
`define OSR_SS_EA0        5'h0C
`define OSR_SS_EA1        5'h0D
`define OSR_SS_IA0        5'h0E
`define OSR_SS_IA1        5'h0F
`define OSR_SS_LOW        5'h10
`define OSR_SS_HIGH       5'h11
// Reset values and constants
`define OSR_SCALE_ONE     16'h0100
`define OSR_ZERO_NOMINAL  16'h0000
`define OSR_FULL_HIGH     16'h7FFF
`define OSR_FULL_LOW      16'h0000
`endif
